// [xio_cfg.svh]
/*
 * Constants of the eight-line asynchronous digital I/O port: register
 * indexes and byte addresses, field positions, reset values and widths.
 * Assumes it is included by bare name from the package and the modules.
 */
`ifndef XIO_CFG_SVH
`define XIO_CFG_SVH

// ==========================================================================
// Bus geometry
// ==========================================================================
`define XIO_ADDR_W 18
`define XIO_DATA_W 32

// ==========================================================================
// Register indexes; byte address is four times the index
// ==========================================================================
`define XIO_DIR_IDX 47100
`define XIO_DATA_IDX 47110
`define XIO_SCTL_IDX 47120
`define XIO_CAPL_IDX 47121
`define XIO_CAPC_IDX 47122
`define XIO_DIR_ADDR 18'(`XIO_DIR_IDX * 4)
`define XIO_DATA_ADDR 18'(`XIO_DATA_IDX * 4)
`define XIO_SCTL_ADDR 18'(`XIO_SCTL_IDX * 4)
`define XIO_CAPL_ADDR 18'(`XIO_CAPL_IDX * 4)
`define XIO_CAPC_ADDR 18'(`XIO_CAPC_IDX * 4)

// ==========================================================================
// Field positions and sizes
// ==========================================================================
`define XIO_LINES 8
`define XIO_GROUPS 2
`define XIO_GROUP_W 4
`define XIO_CNT_W 10
`define XIO_DIR_LOWER_BIT 0
`define XIO_DIR_UPPER_BIT 1
`define XIO_SCTL_LINECAP_BIT 0
`define XIO_SCTL_CNTCAP_BIT 1
`define XIO_CNT2_LSB 16

// ==========================================================================
// Special input roles (line numbers)
// ==========================================================================
`define XIO_REF_SECONDS_LINE 2
`define XIO_CNT1_COUNT_LINE 3
`define XIO_CNT2_COUNT_LINE 4
`define XIO_CNT1_CLEAR_LINE 5
`define XIO_CNT2_CLEAR_LINE 7

// ==========================================================================
// Reset values
// ==========================================================================
`define XIO_DIR_RESET 2'h0
`define XIO_LATCH_RESET 8'h00
`define XIO_SCTL_RESET 2'h0

`endif

// [xio_pkg.sv]
/*
 * Types shared by the digital I/O port modules.
 * Assumes xio_cfg.svh is on the include path.
 */
`include "xio_cfg.svh"

package xio_pkg;

    // ======================================================================
    // Data types
    // ======================================================================
    typedef logic [`XIO_LINES-1:0] xio_lines_t; // One bit per line
    typedef logic [`XIO_CNT_W-1:0] xio_count_t; // Encoder counter value

    // Register selected by the current bus address
    typedef enum {
        XIO_SEL_DIR,
        XIO_SEL_DATA,
        XIO_SEL_SCTL,
        XIO_SEL_CAPL,
        XIO_SEL_CAPC,
        XIO_SEL_NONE
    } xio_sel_e;

endpackage

// [xio_enc_counter.sv]
/*
 * One 10-bit incremental encoder counter: counts rising edges of its count
 * line and clears while its clear line is high.
 * Assumes count and clear lines are synchronous to clk.
 */
`timescale 1ns/1ps
`include "xio_cfg.svh"

module xio_enc_counter (
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic countLine,
    input wire logic clearLine,
    output xio_pkg::xio_count_t value
);

    // ======================================================================
    // Edge detect and count
    // ======================================================================
    logic countPrev_reg; // Count line one cycle back
    xio_pkg::xio_count_t value_reg; // Counter state
    xio_pkg::xio_count_t value_next; // Counter next value
    wire logic countRise = countLine & ~countPrev_reg; // Rising edge seen

    // Clear has priority so a held clear pins the counter at zero
    assign value_next = clearLine ? '0 :
                        countRise ? value_reg + 1'b1 : value_reg; // R14
    assign value = value_reg;

    // Counter only runs while its sampling mode is enabled
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            countPrev_reg <= 1'b0;
            value_reg <= '0;
        end else begin
            countPrev_reg <= countLine;
            if (enable) begin
                value_reg <= value_next;
            end
        end
    end

    // ======================================================================
    // Checks
    // ======================================================================
    a_clear_wins: assert property (@(posedge clk) disable iff (rst) // R14
        enable && clearLine |=> value == '0)
        else $error("counter not cleared");

    a_count_step: assert property (@(posedge clk) disable iff (rst) // R14
        enable && !clearLine && countLine && !countPrev_reg
        |=> value == $past(value) + 1'b1)
        else $error("counter missed a rising edge");

endmodule // xio_enc_counter

// [xio_port.sv]
/*
 * Eight-line asynchronous digital I/O port with APB register access,
 * per-group direction, output latch, pin readback, trigger-synchronous
 * line capture and two encoder counters captured on trigger.
 * Assumes pins and the trigger input are synchronous to clk (10 MHz) and
 * that the pin wire is resolved from xioOut/xioOe outside this module.
 */
// Decided for this implementation: the APB interface to the registers.
// Contract
// R1 - Eight lines in two four-line groups
// R2 - Direction bit 0 sets lower group output
// R3 - Direction bit 1 sets upper group output
// R4 - Software ORs group settings into one write
// R5 - Lines run under software control only
// R6 - Data read returns present pin levels
// R7 - Bit n is line n; upper bytes discarded
// R8 - Writes touch only output groups
// R9 - Lines 2,3,4,5,7 carry special input roles
// R10 - Software sets special-role groups to input
// R11 - Counters need both groups as inputs
// R12 - Reads return all eight bits unmasked
// R13 - Capture all lines on each trigger
// R14 - Capture two 10-bit counters on trigger
// R15 - Sampling modes need timestamp feature installed
// R16 - Both groups are inputs after reset
// R17 - Output latch drives group once switched
`timescale 1ns/1ps
`include "xio_cfg.svh"

module xio_port #(
    parameter bit TS_INSTALLED = 1'b1 // Timestamp feature fitted
) (
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`XIO_ADDR_W-1:0] paddr,
    input wire logic [`XIO_DATA_W-1:0] pwdata,
    output logic [`XIO_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Lines
    input wire logic [`XIO_LINES-1:0] xioIn,
    output logic [`XIO_LINES-1:0] xioOut,
    output logic [`XIO_LINES-1:0] xioOe,
    // Trigger event from the acquisition side
    input wire logic trigEvent
);

    // Checks run on clk and pause while reset holds
    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (rst);

    // ======================================================================
    // Address decode
    // ======================================================================
    // Full compare, so no alias lets a stray write land
    // Byte address is four times the register index
    xio_pkg::xio_sel_e sel; // Register addressed this cycle
    assign sel = (paddr == `XIO_DIR_ADDR) ? xio_pkg::XIO_SEL_DIR :
                 (paddr == `XIO_DATA_ADDR) ? xio_pkg::XIO_SEL_DATA :
                 (paddr == `XIO_SCTL_ADDR) ? xio_pkg::XIO_SEL_SCTL :
                 (paddr == `XIO_CAPL_ADDR) ? xio_pkg::XIO_SEL_CAPL :
                 (paddr == `XIO_CAPC_ADDR) ? xio_pkg::XIO_SEL_CAPC :
                 xio_pkg::XIO_SEL_NONE;

    // ======================================================================
    // Bus handshake
    // ======================================================================
    // One wait state: first access cycle loads prdata, second completes.
    // This keeps every bus output straight from a flop.
    // Costs one cycle per access; software never notices
    logic pready_reg; // Access completes this cycle
    logic pslverr_reg; // Error for the completing access
    logic [`XIO_DATA_W-1:0] prdata_reg; // Read data for the completing access
    wire logic accFirst = psel & penable & ~pready_reg; // Load answer
    wire logic accDone = psel & penable & pready_reg; // Transfer ends
    wire logic wrDone = accDone & pwrite; // Write takes effect
    wire logic unmapped = (sel == xio_pkg::XIO_SEL_NONE); // No register
    wire logic roTarget = (sel == xio_pkg::XIO_SEL_CAPL) |
                          (sel == xio_pkg::XIO_SEL_CAPC); // Read-only
    wire logic wrDir = wrDone & (sel == xio_pkg::XIO_SEL_DIR);
    wire logic wrData = wrDone & (sel == xio_pkg::XIO_SEL_DATA);
    wire logic wrSctl = wrDone & (sel == xio_pkg::XIO_SEL_SCTL);
    // Refused writes complete with pslverr and change nothing

    // ======================================================================
    // Register state
    // ======================================================================
    logic [`XIO_GROUPS-1:0] dirReg_reg; // Group direction, 1 = output
    xio_pkg::xio_lines_t latch_reg; // Output latch
    xio_pkg::xio_lines_t oe_reg; // Per-line drive enable
    xio_pkg::xio_lines_t pinSample_reg; // Sampled pin levels
    logic [1:0] sctl_reg; // Sampling mode enables
    xio_pkg::xio_lines_t capLines_reg; // Lines captured at trigger
    xio_pkg::xio_count_t capCnt1_reg; // Counter one at trigger
    xio_pkg::xio_count_t capCnt2_reg; // Counter two at trigger
    xio_pkg::xio_count_t cnt1Value; // Live counter one
    xio_pkg::xio_count_t cnt2Value; // Live counter two

    // Modes exist only when the timestamp feature is fitted
    // Without it only plain register access is offered
    wire logic lineCapEn = TS_INSTALLED & sctl_reg[`XIO_SCTL_LINECAP_BIT]; // R15
    wire logic cntCapEn = TS_INSTALLED & sctl_reg[`XIO_SCTL_CNTCAP_BIT]; // R15

    // ======================================================================
    // Read mux
    // ======================================================================
    logic [`XIO_DATA_W-1:0] rdMux; // Read value for current address
    wire logic [`XIO_DATA_W-1:0] capcWord =
        {6'h00, capCnt2_reg, 6'h00, capCnt1_reg}; // Counters side by side
    // All eight bits returned, special-role lines included
    // Software masks special-role bits itself
    // Unmapped reads answer zero with the error
    assign rdMux = (sel == xio_pkg::XIO_SEL_DIR) ? {30'h0, dirReg_reg} :
                   (sel == xio_pkg::XIO_SEL_DATA) ? {24'h0, pinSample_reg} : // R6 R12
                   (sel == xio_pkg::XIO_SEL_SCTL) ? {30'h0, sctl_reg} :
                   (sel == xio_pkg::XIO_SEL_CAPL) ? {24'h0, capLines_reg} :
                   (sel == xio_pkg::XIO_SEL_CAPC) ? capcWord :
                   32'h0000_0000;

    // ======================================================================
    // APB answer flops
    // ======================================================================
    // Answer is latched in the first access cycle and held to completion
    // prdata keeps its value after; only pready marks it valid
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= accFirst;
            if (accFirst) begin
                pslverr_reg <= unmapped | (pwrite & roTarget);
                prdata_reg <= pwrite ? 32'h0000_0000 : rdMux;
            end else if (accDone) begin
                pslverr_reg <= 1'b0;
            end
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;

    // ======================================================================
    // Direction and sampling control
    // ======================================================================
    // Reset leaves both groups input, so nothing drives until told to
    // Only bits 1:0 are kept; higher bits read back as zero
    // Sampling enables are dead when the feature is absent
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dirReg_reg <= `XIO_DIR_RESET; // R16
            sctl_reg <= `XIO_SCTL_RESET;
        end else begin
            if (wrDir) begin
                dirReg_reg[`XIO_DIR_LOWER_BIT] <= pwdata[`XIO_DIR_LOWER_BIT]; // R2
                dirReg_reg[`XIO_DIR_UPPER_BIT] <= pwdata[`XIO_DIR_UPPER_BIT]; // R3
            end
            if (wrSctl) begin
                sctl_reg <= pwdata[1:0];
            end
        end
    end

    // ======================================================================
    // Per-group latch and drive enable
    // ======================================================================
    // Each group is buffered on its own; bits 8..31 never reach a group
    // Enable follows a direction write on the same edge,
    // so direction and enable never disagree for a cycle
    genvar g;
    generate
        for (g = 0; g < `XIO_GROUPS; g++) begin : gGroup // R1
            localparam int LSB = g * `XIO_GROUP_W;
            // Writes only land in groups that are outputs; the latch keeps
            // its value so a later switch to output drives it at once
            wire logic grpOut = dirReg_reg[g];
            wire logic dirNext = wrDir ? pwdata[g] : grpOut;
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    latch_reg[LSB +: `XIO_GROUP_W] <= 4'(`XIO_LATCH_RESET >> LSB);
                    oe_reg[LSB +: `XIO_GROUP_W] <= 4'h0; // R16
                end else begin
                    if (wrData && grpOut) begin
                        latch_reg[LSB +: `XIO_GROUP_W] <=
                            pwdata[LSB +: `XIO_GROUP_W]; // R7 R8
                    end
                    oe_reg[LSB +: `XIO_GROUP_W] <= {`XIO_GROUP_W{dirNext}}; // R17
                end
            end
        end
    endgenerate

    assign xioOut = latch_reg; // R17
    assign xioOe = oe_reg;

    // ======================================================================
    // Pin sampling and trigger capture
    // ======================================================================
    // Pins are sampled every cycle with no link to the sampling clock, so
    // a read sees output lines too, reflecting the pattern being driven
    // Capture ignores direction: outputs are captured as driven
    // A read shows the level sampled before the first access
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pinSample_reg <= 8'h00;
            capLines_reg <= 8'h00;
            capCnt1_reg <= 10'h000;
            capCnt2_reg <= 10'h000;
        end else begin
            pinSample_reg <= xioIn; // R5 R6
            if (trigEvent && lineCapEn) begin
                capLines_reg <= xioIn; // R13
            end
            if (trigEvent && cntCapEn) begin
                capCnt1_reg <= cnt1Value; // R14
                capCnt2_reg <= cnt2Value; // R14
            end
        end
    end

    // ======================================================================
    // Encoder counters
    // ======================================================================
    // Line 2 is the reference-seconds input; it is consumed by the
    // timestamp engine outside, so here it only appears in reads.
    // The counters assume software left both groups as inputs.
    // An output group would feed the driven pattern instead
    // One shared enable starts and stops both together
    xio_enc_counter u_cnt1 (
        .clk(clk),
        .rst(rst),
        .enable(cntCapEn),
        .countLine(xioIn[`XIO_CNT1_COUNT_LINE]), // R9
        .clearLine(xioIn[`XIO_CNT1_CLEAR_LINE]), // R9
        .value(cnt1Value)
    );

    xio_enc_counter u_cnt2 (
        .clk(clk),
        .rst(rst),
        .enable(cntCapEn),
        .countLine(xioIn[`XIO_CNT2_COUNT_LINE]), // R9
        .clearLine(xioIn[`XIO_CNT2_CLEAR_LINE]), // R9
        .value(cnt2Value)
    );

    // ======================================================================
    // Checks
    // ======================================================================
    a_oe_follows_dir: assert property (@(posedge clk) disable iff (rst) // R2
        wrDir |=> xioOe == {{4{$past(pwdata[1])}}, {4{$past(pwdata[0])}}})
        else $error("drive enable does not follow direction write");

    a_upper_ignored: assert property (@(posedge clk) disable iff (rst) // R3
        wrData && !dirReg_reg[1] |=> $stable(xioOut[7:4]))
        else $error("input upper group took written data");

    a_lower_written: assert property (@(posedge clk) disable iff (rst) // R8
        wrData && dirReg_reg[0] |=> xioOut[3:0] == $past(pwdata[3:0]))
        else $error("output lower group missed write");

    a_lower_ignored: assert property (@(posedge clk) disable iff (rst) // R8
        wrData && !dirReg_reg[0] |=> $stable(xioOut[3:0]))
        else $error("input lower group took written data");

    a_read_pins: assert property (@(posedge clk) disable iff (rst) // R6
        accFirst && !pwrite && sel == xio_pkg::XIO_SEL_DATA
        |=> prdata == {24'h0, $past(pinSample_reg)} && pready)
        else $error("data read does not return pin levels");

    a_apb_wait: assert property (@(posedge clk) disable iff (rst) // R7
        accFirst |=> pready ##1 !pready)
        else $error("access did not complete after one wait state");

    a_line_capture: assert property (@(posedge clk) disable iff (rst) // R13
        trigEvent && lineCapEn |=> capLines_reg == $past(xioIn))
        else $error("lines not captured on trigger");

    a_no_feature: assert property (@(posedge clk) disable iff (rst) // R15
        !TS_INSTALLED |-> capLines_reg == 8'h00 && capcWord == 32'h0000_0000)
        else $error("sampling active without timestamp feature");

    a_reset_input: assert property (@(posedge clk) // R16
        $fell(rst) |-> xioOe == 8'h00 && dirReg_reg == 2'h0)
        else $error("line driven after reset");

    a_upper_written: assert property ( // R8
        wrData && dirReg_reg[1] |=> xioOut[7:4] == $past(pwdata[7:4]))
        else $error("output upper group missed write");

    a_oe_tracks_dir: assert property ( // R1
        xioOe == {{4{dirReg_reg[1]}}, {4{dirReg_reg[0]}}})
        else $error("group drive enable split from direction");

    a_latch_holds: assert property ( // R17
        !wrData |=> $stable(xioOut))
        else $error("output latch changed without a write");

    a_unmapped_err: assert property ( // R5
        accFirst && unmapped |=> pready && pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");

    a_ro_refused: assert property ( // R13
        accFirst && pwrite && roTarget |=> pready && pslverr)
        else $error("capture register write not refused");

    a_mapped_ok: assert property ( // R5
        accFirst && !unmapped && !(pwrite && roTarget) |=> pready && !pslverr)
        else $error("legal access flagged as error");

    a_err_ready: assert property ( // R5
        pslverr |-> pready)
        else $error("error response without ready");

    a_write_zero: assert property ( // R6
        accFirst && pwrite |=> prdata == 32'h0000_0000)
        else $error("write returned read data");

    a_dir_readback: assert property ( // R2
        accFirst && !pwrite && sel == xio_pkg::XIO_SEL_DIR
        |=> prdata == {30'h0, $past(dirReg_reg)})
        else $error("direction readback wrong");

    a_pins_sampled: assert property ( // R6
        !$past(rst) |-> pinSample_reg == $past(xioIn))
        else $error("pin level not sampled");

    a_cnt_capture: assert property ( // R14
        trigEvent && cntCapEn |=> capcWord == {6'h00, $past(cnt2Value), 6'h00, $past(cnt1Value)})
        else $error("counters not captured on trigger");

    a_cap_hold: assert property ( // R13
        !trigEvent |=> $stable(capLines_reg) && $stable(capcWord))
        else $error("capture changed without trigger");

    a_cnt_gated: assert property ( // R15
        !cntCapEn |=> $stable(cnt1Value) && $stable(cnt2Value))
        else $error("counter ran with its mode off");

endmodule // xio_port

// [xio_ext_equip.sv]
/*
 * Model of the external instruments wired to the eight digital lines.
 * Assumes the bench sets drivePattern at rising clock edges and that the
 * port's xioOut/xioOe are registered outputs of the device under test.
 */
`timescale 1ns/1ps

// ==========================================================================
// External equipment on the coaxial lines
// ==========================================================================
module xio_ext_equip (
    input wire logic [7:0] drivePattern, // Level the equipment would drive
    input wire logic [7:0] xioOut, // Device output latch
    input wire logic [7:0] xioOe, // Device drive enables
    output logic [7:0] lineLevel // Resolved wire seen by the device
);
    // Resolve each line: the equipment lets go wherever the device drives,
    // so there is never contention to model
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            lineLevel[i] = xioOe[i] ? xioOut[i] : drivePattern[i];
        end
    end
endmodule // xio_ext_equip

// [tb_top.sv]
/*
 * Self-checking bench for the digital I/O port: APB master tasks, pin
 * stimulus through the equipment model, trigger capture and counters.
 * Assumes xio_cfg.svh on the include path and a 10 MHz clock.
 */
`timescale 1ns/1ps
`include "xio_cfg.svh"

module tb_top;
    // ======================================================================
    // Signals
    // ======================================================================
    logic clk, rst, psel, penable, pwrite, trigEvent, pready, pslverr;
    logic [`XIO_ADDR_W-1:0] paddr; // Byte address
    logic [31:0] pwdata, prdata; // Bus data
    logic [7:0] xioIn, xioOut, xioOe, drivePattern; // Line side
    logic [31:0] rd; // Last read data
    logic err; // Last error response
    logic [31:0] prdataBare, rdBare; // Featureless port read data
    int mismatches, checks, cycles; // Score and watchdog

    xio_port #(.TS_INSTALLED(1'b1)) uut (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .xioIn(xioIn),
        .xioOut(xioOut), .xioOe(xioOe), .trigEvent(trigEvent));
    xio_ext_equip equip (.drivePattern(drivePattern), .xioOut(xioOut),
        .xioOe(xioOe), .lineLevel(xioIn));
    // Same bus, no timestamp feature: captures must stay empty
    xio_port #(.TS_INSTALLED(1'b0)) uutBare (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdataBare), .pready(), .pslverr(), .xioIn(xioIn),
        .xioOut(), .xioOe(), .trigEvent(trigEvent));

    // ======================================================================
    // Clock and watchdog
    // ======================================================================
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Whole run needs under two hundred cycles; a hang ends here
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            end_of_test();
        end
    end

    // ======================================================================
    // Shared tasks
    // ======================================================================
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; waits on pready, no assumed latency
    task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        rdBare = prdataBare;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Two edges so registered line outputs have surely landed
    task automatic settle();
        repeat (2) @(posedge clk);
    endtask
    // Hold a pin pattern for two cycles, then drop back to zero
    task automatic pins(input logic [7:0] v);
        @(posedge clk);
        drivePattern <= v;
        settle();
        drivePattern <= 8'h00;
        settle();
    endtask
    task automatic trigger();
        @(posedge clk);
        trigEvent <= 1'b1;
        @(posedge clk);
        trigEvent <= 1'b0;
        settle();
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ======================================================================
    // Scenarios
    // ======================================================================
    task automatic test_reset();
        apb(1'b0, `XIO_DIR_ADDR, 32'h0);
        check(rd, 32'h0);
        check({24'h0, xioOe}, 32'h0);
        @(posedge clk);
        drivePattern <= 8'h3C;
        apb(1'b0, `XIO_DATA_ADDR, 32'h0);
        check(rd, 32'h3C);
        $display("test reset done");
    endtask
    // Both groups out; upper bytes of the write must vanish
    task automatic test_output();
        apb(1'b1, `XIO_DIR_ADDR, 32'h1 | 32'h2);
        apb(1'b1, `XIO_DATA_ADDR, 32'hFFFFFFA5);
        settle();
        check({24'h0, xioOe}, 32'hFF);
        check({24'h0, xioOut}, 32'hA5);
        apb(1'b0, `XIO_DATA_ADDR, 32'h0);
        check(rd, 32'hA5);
        apb(1'b0, `XIO_DIR_ADDR, 32'h0);
        check(rd, 32'h3);
        $display("test output done");
    endtask
    // Mixed mode: input group ignores writes, latch reappears on switch
    task automatic test_groups();
        apb(1'b1, `XIO_DIR_ADDR, 32'h1);
        settle();
        check({24'h0, xioOe}, 32'h0F);
        drivePattern <= 8'hC3;
        apb(1'b1, `XIO_DATA_ADDR, 32'h5A);
        apb(1'b0, `XIO_DATA_ADDR, 32'h0);
        check(rd, 32'hCA);
        apb(1'b1, `XIO_DIR_ADDR, 32'h2);
        settle();
        check({24'h0, xioOe}, 32'hF0);
        check({28'h0, xioOut[7:4]}, 32'hA);
        apb(1'b0, `XIO_DATA_ADDR, 32'h0);
        check(rd, 32'hA3);
        $display("test groups done");
    endtask
    task automatic test_refused();
        apb(1'b0, 18'h00100, 32'h0);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        apb(1'b1, `XIO_CAPL_ADDR, 32'hFF);
        check({31'h0, err}, 32'h1);
        $display("test refused done");
    endtask
    // Trigger capture of lines, then counters with clear
    task automatic test_capture();
        apb(1'b1, `XIO_DIR_ADDR, 32'h0);
        apb(1'b1, `XIO_SCTL_ADDR, 32'h1);
        @(posedge clk);
        drivePattern <= 8'h96;
        settle();
        trigger();
        apb(1'b0, `XIO_CAPL_ADDR, 32'h0);
        check(rd, 32'h96);
        check(rdBare, 32'h0);
        @(posedge clk);
        drivePattern <= 8'h00;
        apb(1'b1, `XIO_SCTL_ADDR, 32'h3);
        repeat (3) pins(8'h08);
        repeat (2) pins(8'h10);
        trigger();
        apb(1'b0, `XIO_CAPC_ADDR, 32'h0);
        check(rd, 32'h00020003);
        check(rdBare, 32'h0);
        pins(8'hA0);
        trigger();
        apb(1'b0, `XIO_CAPC_ADDR, 32'h0);
        check(rd, 32'h0);
        $display("test capture done");
    endtask

    // ======================================================================
    // Main sequence
    // ======================================================================
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        trigEvent = 1'b0;
        drivePattern = 8'h00;
        mismatches = 0;
        checks = 0;
        cycles = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        test_reset();
        test_output();
        test_groups();
        test_refused();
        test_capture();
        end_of_test();
    end
endmodule // tb_top
